// >>> inc/dep_pkg.sv
// Package for the debug and error return program counter block
package dep_pkg;
  localparam int unsigned DEP_XLEN = 32;
  // Register numbers and selects as seen by coprocessor moves
  localparam logic [4:0] DEP_DEBUG_PC_REGNUM = 5'h18;
  localparam logic [2:0] DEP_DEBUG_PC_SEL = 3'h0;
  localparam logic [4:0] DEP_ERROR_PC_REGNUM = 5'h1E;
  localparam logic [2:0] DEP_ERROR_PC_SEL = 3'h0;
  // Mode field position inside the third configuration register
  localparam int unsigned DEP_MODE_FIELD_LSB = 14;
  localparam int unsigned DEP_MODE_FIELD_MSB = 15;
  // Reset values (documented as unknown; zero chosen)
  localparam logic [31:0] DEP_DEBUG_PC_RST = 32'h0000_0000;
  localparam logic [31:0] DEP_ERROR_PC_RST = 32'h0000_0000;
  localparam logic [1:0] DEP_MODE_RST = 2'h0;

  typedef enum logic [1:0] {
    DEP_SRC_NONE,
    DEP_SRC_DEBUG,
    DEP_SRC_ERROR
  } dep_src_t;
endpackage

// >>> rtl/dep_capture.sv
// Selects the address captured for an exception
`timescale 1ns/1ps
module dep_capture
  import dep_pkg::*;
(
  input wire logic [31:0] i_instr_pc,
  input wire logic [31:0] i_branch_pc,
  input wire logic i_in_delay_slot,
  input wire logic i_async,
  input wire logic [31:0] i_resume_pc,
  output logic [31:0] o_capture_pc
);
  always_comb begin
    if (i_async) begin
      o_capture_pc = i_resume_pc;
    end else if (i_in_delay_slot) begin
      o_capture_pc = i_branch_pc;
    end else begin
      o_capture_pc = i_instr_pc;
    end
  end
endmodule // dep_capture

// >>> rtl/dep_return_pc.sv
// Debug and error return program counter registers
`timescale 1ns/1ps
// Behaviour
// - A 32-bit read/write debug return register holds the resume address after a debug exception.
// - A precise debug exception loads the address of the instruction that caused it.
// - In a delay slot the preceding branch address is captured and the delay-slot flag is set.
// - An asynchronous debug interrupt loads the address where execution should resume.
// - Reading the debug return register gives bits 31:1 stored and bit 0 from the low mode bit.
// - Writing it stores bits 31:1, clears bit 0, clears the high mode bit and loads the low from bit 0.
// - The debug return instruction jumps to the address held in the debug return register.
// - A separate read/write error return register serves error exceptions.
// - Reset, soft reset and non-maskable interrupt save the current program counter there.
// - Error return register bits 31:1 are significant and writable; a write clears bit 0.
// - An error exception captures the faulting address, or the branch address in a delay slot; with i_debug_async in the same cycle it takes i_resume_pc.
// - No delay-slot indicator goes with the error return register.
// - Reading the error return register gives bits 31:1 stored and bit 0 from the low mode bit.
// - Writing it stores bits 31:1, clears bit 0, clears the high mode bit and loads the low from bit 0.
module dep_return_pc
  import dep_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Exception events, one-cycle pulses from the pipeline
  input wire logic i_debug_exc,
  input wire logic i_debug_async,
  input wire logic i_error_exc,
  input wire logic i_reset_exc,
  input wire logic [31:0] i_instr_pc,
  input wire logic [31:0] i_branch_pc,
  input wire logic i_in_delay_slot,
  input wire logic [31:0] i_resume_pc,
  input wire logic [31:0] i_current_pc,
  // Coprocessor moves
  input wire logic i_move_to,
  input wire logic [4:0] i_move_reg,
  input wire logic [2:0] i_move_sel,
  input wire logic [31:0] i_move_data,
  output logic [31:0] o_move_rdata,
  output logic o_move_hit,
  // Mode field held by the configuration register
  input wire logic [1:0] i_mode_field,
  output logic o_mode_we,
  output logic [1:0] o_mode_wdata,
  // Debug control flag and return jump
  output logic o_delay_slot_we,
  output logic o_delay_slot_flag,
  input wire logic i_debug_return,
  output logic o_jump_valid,
  output logic [31:0] o_jump_pc,
  output logic [31:0] o_debug_return_pc,
  output logic [31:0] o_error_return_pc
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [31:0] debug_pc;
    logic [31:0] error_pc;
    logic dbd_we;
    logic dbd;
    logic jump;
    logic mode_we;
    logic [1:0] mode;
  } dep_state_t;

  dep_state_t st_r;
  dep_state_t st_nxt;
  logic [31:0] cap_pc;
  logic hit_dbg;
  logic hit_err;

  function automatic logic sel_hit(input logic [4:0] r, input logic [2:0] s,
                                   input logic [4:0] rr, input logic [2:0] ss);
    sel_hit = (r == rr) && (s == ss);
  endfunction

  assign hit_dbg = sel_hit(i_move_reg, i_move_sel, DEP_DEBUG_PC_REGNUM, DEP_DEBUG_PC_SEL);
  assign hit_err = sel_hit(i_move_reg, i_move_sel, DEP_ERROR_PC_REGNUM, DEP_ERROR_PC_SEL);

  dep_capture u_capture (
    .i_instr_pc(i_instr_pc),
    .i_branch_pc(i_branch_pc),
    .i_in_delay_slot(i_in_delay_slot),
    .i_async(i_debug_async),
    .i_resume_pc(i_resume_pc),
    .o_capture_pc(cap_pc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Hardware capture outranks a software write in the same cycle
  always_comb begin
    st_nxt = st_r;
    st_nxt.dbd_we = 1'b0;
    st_nxt.jump = 1'b0;
    st_nxt.mode_we = 1'b0;
    if (i_move_to && hit_dbg) begin
      st_nxt.debug_pc = {i_move_data[31:1], 1'b0};
      st_nxt.mode_we = 1'b1;
      st_nxt.mode = {1'b0, i_move_data[0]};
    end
    if (i_move_to && hit_err) begin
      st_nxt.error_pc = {i_move_data[31:1], 1'b0};
      st_nxt.mode_we = 1'b1;
      st_nxt.mode = {1'b0, i_move_data[0]};
    end
    if (i_debug_exc || i_debug_async) begin
      st_nxt.debug_pc = cap_pc;
      st_nxt.dbd_we = 1'b1;
      st_nxt.dbd = i_in_delay_slot && !i_debug_async;
    end
    if (i_reset_exc) begin
      st_nxt.error_pc = i_current_pc;
    end else if (i_error_exc) begin
      // No delay-slot flag is produced here
      st_nxt.error_pc = cap_pc;
    end
    if (i_debug_return) begin
      st_nxt.jump = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '{debug_pc: DEP_DEBUG_PC_RST, error_pc: DEP_ERROR_PC_RST, dbd_we: 1'b0, dbd: 1'b0,
                jump: 1'b0, mode_we: 1'b0, mode: DEP_MODE_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path is combinational so a move-from sees the live mode bit
  always_comb begin
    o_move_rdata = 32'h0000_0000;
    if (hit_dbg) begin
      o_move_rdata = {st_r.debug_pc[31:1], i_mode_field[0]};
    end else if (hit_err) begin
      o_move_rdata = {st_r.error_pc[31:1], i_mode_field[0]};
    end
  end

  assign o_move_hit = hit_dbg || hit_err;
  assign o_mode_we = st_r.mode_we;
  assign o_mode_wdata = st_r.mode;
  assign o_delay_slot_we = st_r.dbd_we;
  assign o_delay_slot_flag = st_r.dbd;
  assign o_jump_valid = st_r.jump;
  assign o_jump_pc = st_r.debug_pc;
  assign o_debug_return_pc = st_r.debug_pc;
  assign o_error_return_pc = st_r.error_pc;
endmodule // dep_return_pc

// >>> tb/dep_return_pc_asserts.sv
// Assertion checker for the return program counter block
`timescale 1ns/1ps
module dep_return_pc_asserts
  import dep_pkg::*;
(
  input wire logic i_clk, i_rst_n, i_debug_exc, i_debug_async, i_reset_exc, i_in_delay_slot, i_error_exc,
  input wire logic i_move_to, i_debug_return, o_move_hit, o_mode_we, o_delay_slot_we, o_delay_slot_flag,
  input wire logic o_jump_valid,
  input wire logic [31:0] i_instr_pc, i_branch_pc, i_resume_pc, i_current_pc, i_move_data, o_move_rdata,
  input wire logic [31:0] o_jump_pc, o_debug_return_pc, o_error_return_pc,
  input wire logic [4:0] i_move_reg,
  input wire logic [2:0] i_move_sel,
  input wire logic [1:0] i_mode_field, o_mode_wdata
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire dr = i_move_reg == DEP_DEBUG_PC_REGNUM && i_move_sel == DEP_DEBUG_PC_SEL;
  wire ew = i_move_to && i_move_reg == DEP_ERROR_PC_REGNUM && i_move_sel == DEP_ERROR_PC_SEL;
  wire dx = i_debug_exc && !i_debug_async;
  wire er = i_move_reg == DEP_ERROR_PC_REGNUM && i_move_sel == DEP_ERROR_PC_SEL;
  sequence jmp_s;
    o_jump_valid && o_jump_pc == o_debug_return_pc;
  endsequence
  dbg_cap_a: assert property (dx |=> o_debug_return_pc == $past(i_in_delay_slot ? i_branch_pc : i_instr_pc))
    else $error("debug capture wrong");
  dly_flag_a: assert property (dx |=> o_delay_slot_we && o_delay_slot_flag == $past(i_in_delay_slot))
    else $error("delay flag wrong");
  async_cap_a: assert property (i_debug_async |=> o_debug_return_pc == $past(i_resume_pc))
    else $error("async capture wrong");
  dbg_rd_a: assert property (dr |-> o_move_hit && o_move_rdata == {o_debug_return_pc[31:1], i_mode_field[0]})
    else $error("debug read wrong");
  dbg_wr_a: assert property (i_move_to && dr && !i_debug_exc && !i_debug_async |=>
    o_debug_return_pc == {$past(i_move_data[31:1]), 1'b0} && o_mode_we && o_mode_wdata == {1'b0, $past(i_move_data[0])})
    else $error("debug write wrong");
  jump_a: assert property (i_debug_return |=> jmp_s)
    else $error("return jump wrong");
  rst_cap_a: assert property (i_reset_exc |=> o_error_return_pc == $past(i_current_pc))
    else $error("reset capture wrong");
  err_wr_a: assert property (ew && !i_reset_exc && !i_error_exc |=> o_error_return_pc == {$past(i_move_data[31:1]), 1'b0})
    else $error("error write wrong");
  err_cap_a: assert property (i_error_exc && !i_reset_exc |=>
    o_error_return_pc == $past(i_in_delay_slot ? i_branch_pc : i_instr_pc))
    else $error("error capture wrong");
  err_rd_a: assert property (er |-> o_move_hit && o_move_rdata == {o_error_return_pc[31:1], i_mode_field[0]})
    else $error("error read wrong");
  async_flag_a: assert property (i_debug_async |=> o_delay_slot_we && !o_delay_slot_flag)
    else $error("async flag wrong");
  jump_once_a: assert property (!i_debug_return |=> !o_jump_valid)
    else $error("spurious jump");
endmodule // dep_return_pc_asserts
bind dep_return_pc dep_return_pc_asserts dep_return_pc_asserts_inst (.*);

// >>> tb/dep_return_pc_tb_top.sv
// Self-checking bench for the return program counter block
`timescale 1ns/1ps
module dep_return_pc_tb_top;
  logic i_clk = 0, i_rst_n = 0, i_debug_exc = 0, i_debug_async = 0, i_error_exc = 0, i_reset_exc = 0;
  logic i_in_delay_slot = 0, i_move_to = 0, i_debug_return = 0, jv = 0;
  logic mw = 0, dw = 0, df = 0;
  logic [1:0] md = 0;
  logic [31:0] i_instr_pc = 0, i_branch_pc = 0, i_resume_pc = 0, i_current_pc = 0, i_move_data = 0, ed = 0, ee = 0, jp = 0;
  logic [4:0] i_move_reg = 0;
  logic [2:0] i_move_sel = 0;
  logic [1:0] i_mode_field = 0, o_mode_wdata;
  logic [31:0] o_move_rdata, o_jump_pc, o_debug_return_pc, o_error_return_pc;
  logic o_move_hit, o_mode_we, o_delay_slot_we, o_delay_slot_flag, o_jump_valid;
  integer seed = 32'h2215, num_errors = 0, n_checks = 0, k;
  dep_return_pc dep_return_pc_inst (.*);
  initial forever #2.5 i_clk = ~i_clk;
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task stop_test;
    if (num_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1;
    repeat (500) begin
      @(negedge i_clk);
      chk(o_debug_return_pc, ed);
      chk(o_error_return_pc, ee);
      chk({31'h0, o_jump_valid}, {31'h0, jv});
      if (jv) chk(o_jump_pc, jp);
      chk(o_move_rdata, (i_move_reg == 5'h18 && i_move_sel == 3'h0) ? {ed[31:1], i_mode_field[0]} :
        (i_move_reg == 5'h1E && i_move_sel == 3'h0) ? {ee[31:1], i_mode_field[0]} : 32'h0);
      chk({31'h0, o_move_hit}, {31'h0, i_move_sel == 3'h0 && (i_move_reg == 5'h18 || i_move_reg == 5'h1E)});
      chk({31'h0, o_mode_we}, {31'h0, mw});
      chk({30'h0, o_mode_wdata}, {30'h0, md});
      chk({31'h0, o_delay_slot_we}, {31'h0, dw});
      chk({31'h0, o_delay_slot_flag}, {31'h0, df});
      @(posedge i_clk);
      // Model sees the same settled inputs the design samples at this edge
      if (i_debug_async) ed = i_resume_pc;
      else if (i_debug_exc) ed = i_in_delay_slot ? i_branch_pc : i_instr_pc;
      else if (i_move_to && i_move_reg == 5'h18 && i_move_sel == 3'h0) ed = {i_move_data[31:1], 1'b0};
      if (i_reset_exc) ee = i_current_pc;
      else if (i_error_exc) ee = i_in_delay_slot ? i_branch_pc : i_instr_pc;
      else if (i_move_to && i_move_reg == 5'h1E && i_move_sel == 3'h0) ee = {i_move_data[31:1], 1'b0};
      jv = i_debug_return;
      mw = i_move_to && i_move_sel == 3'h0 && (i_move_reg == 5'h18 || i_move_reg == 5'h1E);
      if (mw) md = {1'b0, i_move_data[0]};
      dw = i_debug_exc || i_debug_async;
      if (dw) df = i_in_delay_slot && !i_debug_async;
      jp = ed;
      k = $random(seed) & 7;
      i_debug_exc <= k == 1;
      i_debug_async <= k == 2;
      i_error_exc <= k == 3;
      i_reset_exc <= k == 4;
      i_move_to <= k > 4;
      i_debug_return <= k[0];
      i_move_reg <= k == 5 ? 5'h18 : k == 6 ? 5'h1E : 5'($random(seed));
      i_move_sel <= k > 6 ? 3'($random(seed)) : 3'h0;
      i_in_delay_slot <= 1'($random(seed));
      i_mode_field <= 2'($random(seed));
      i_instr_pc <= $random(seed);
      i_branch_pc <= $random(seed);
      i_resume_pc <= $random(seed);
      i_current_pc <= $random(seed);
      i_move_data <= $random(seed);
    end
    stop_test;
  end
endmodule // dep_return_pc_tb_top
